// ---- hw/bio_pkg.sv ----
// Purpose: constants for the four bidirectional byte-wide I/O ports
// Assumes: one internal clock MCLK, asynchronous active-low reset
// Notes: internal bus address selects port and latch or direction byte
package bio_pkg;
  localparam int BIO_PORTS = 4;
  localparam int BIO_WIDTH = 8;
  localparam int BIO_ADDR_W = 3;
  // address bit 2 picks direction byte, bits 1:0 pick the port
  localparam int BIO_SEL_DIR = 2;
  localparam logic [BIO_WIDTH-1:0] BIO_DIR_RESET = 8'h00;
  localparam logic [BIO_WIDTH-1:0] BIO_DATA_INIT = 8'h00;
  localparam logic [1:0] BIO_PORT_FIRST = 2'h0;
  localparam logic [1:0] BIO_PORT_SECOND = 2'h1;
  localparam logic [1:0] BIO_PORT_THIRD = 2'h2;
  localparam logic [1:0] BIO_PORT_FOURTH = 2'h3;
endpackage

// ---- hw/bio_ports.sv ----
// Purpose: four byte-wide bidirectional I/O ports on the internal bus
// Assumes: bus signals are on the MCLK domain; pins are asynchronous
// Notes: pins are split into input, output and output enable
module bio_ports
  import bio_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic BUS_SEL,
  input wire logic BUS_WR,
  input wire logic [BIO_ADDR_W-1:0] BUS_ADDR,
  input wire logic [BIO_WIDTH-1:0] BUS_WDATA,
  output logic [BIO_WIDTH-1:0] BUS_RDATA,
  input wire logic [BIO_WIDTH-1:0] FIRST_PORT_LINES_IN,
  output logic [BIO_WIDTH-1:0] FIRST_PORT_LINES_OUT,
  output logic [BIO_WIDTH-1:0] FIRST_PORT_LINES_OE,
  input wire logic [BIO_WIDTH-1:0] SECOND_PORT_LINES_IN,
  output logic [BIO_WIDTH-1:0] SECOND_PORT_LINES_OUT,
  output logic [BIO_WIDTH-1:0] SECOND_PORT_LINES_OE,
  input wire logic [BIO_WIDTH-1:0] THIRD_PORT_LINES_IN,
  output logic [BIO_WIDTH-1:0] THIRD_PORT_LINES_OUT,
  output logic [BIO_WIDTH-1:0] THIRD_PORT_LINES_OE,
  input wire logic [BIO_WIDTH-1:0] FOURTH_PORT_LINES_IN,
  output logic [BIO_WIDTH-1:0] FOURTH_PORT_LINES_OUT,
  output logic [BIO_WIDTH-1:0] FOURTH_PORT_LINES_OE
);

  // one latch and one direction flop group per port
  logic [BIO_WIDTH-1:0] first_data_reg;
  logic [BIO_WIDTH-1:0] second_data_reg;
  logic [BIO_WIDTH-1:0] third_data_reg;
  logic [BIO_WIDTH-1:0] fourth_data_reg;
  logic [BIO_WIDTH-1:0] first_dir_reg;
  logic [BIO_WIDTH-1:0] second_dir_reg;
  logic [BIO_WIDTH-1:0] third_dir_reg;
  logic [BIO_WIDTH-1:0] fourth_dir_reg;
  // indexed views of the flops for the read path
  logic [BIO_WIDTH-1:0] data_view [BIO_PORTS];
  logic [BIO_WIDTH-1:0] dir_view [BIO_PORTS];
  logic [BIO_WIDTH-1:0] pin_meta_reg [BIO_PORTS];
  logic [BIO_WIDTH-1:0] pin_sync_reg [BIO_PORTS];
  logic [BIO_WIDTH-1:0] pin_raw [BIO_PORTS];
  logic [BIO_WIDTH-1:0] rdata_next;
  logic [BIO_PORTS-1:0] data_wr;
  logic [BIO_PORTS-1:0] dir_wr;
  logic [1:0] port_idx;
  logic dir_sel;
  logic rd_en;

  // mixes pin level and latch per bit according to direction
  function automatic logic [BIO_WIDTH-1:0] read_mix(
    input logic [BIO_WIDTH-1:0] dir,
    input logic [BIO_WIDTH-1:0] latch,
    input logic [BIO_WIDTH-1:0] pin
  );
    read_mix = (dir & latch) | (~dir & pin);
  endfunction

  // true when a write strobe targets one byte kind of one port
  function automatic logic wr_hit(
    input logic sel,
    input logic wr,
    input logic [BIO_ADDR_W-1:0] addr,
    input logic [1:0] port,
    input logic want_dir
  );
    wr_hit = sel && wr && (addr[1:0] == port)
             && (addr[BIO_SEL_DIR] == want_dir);
  endfunction

  // bus address decode into port index and byte kind
  assign port_idx = BUS_ADDR[1:0];
  assign dir_sel = BUS_ADDR[BIO_SEL_DIR];
  assign rd_en = BUS_SEL && !BUS_WR;

  // per-port write strobes for the data latch bytes
  assign data_wr[BIO_PORT_FIRST] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                          BIO_PORT_FIRST, 1'b0);
  assign data_wr[BIO_PORT_SECOND] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                           BIO_PORT_SECOND, 1'b0);
  assign data_wr[BIO_PORT_THIRD] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                          BIO_PORT_THIRD, 1'b0);
  assign data_wr[BIO_PORT_FOURTH] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                           BIO_PORT_FOURTH, 1'b0);

  // per-port write strobes for the direction bytes
  assign dir_wr[BIO_PORT_FIRST] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                         BIO_PORT_FIRST, 1'b1);
  assign dir_wr[BIO_PORT_SECOND] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                          BIO_PORT_SECOND, 1'b1);
  assign dir_wr[BIO_PORT_THIRD] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                         BIO_PORT_THIRD, 1'b1);
  assign dir_wr[BIO_PORT_FOURTH] = wr_hit(BUS_SEL, BUS_WR, BUS_ADDR,
                                          BIO_PORT_FOURTH, 1'b1);

  assign pin_raw[BIO_PORT_FIRST] = FIRST_PORT_LINES_IN;
  assign pin_raw[BIO_PORT_SECOND] = SECOND_PORT_LINES_IN;
  assign pin_raw[BIO_PORT_THIRD] = THIRD_PORT_LINES_IN;
  assign pin_raw[BIO_PORT_FOURTH] = FOURTH_PORT_LINES_IN;

  // two-flop synchroniser on every pin input
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < BIO_PORTS; i++) begin
        pin_meta_reg[i] <= BIO_DATA_INIT;
        pin_sync_reg[i] <= BIO_DATA_INIT;
      end
    end else begin
      for (int i = 0; i < BIO_PORTS; i++) begin
        pin_meta_reg[i] <= pin_raw[i];
        pin_sync_reg[i] <= pin_meta_reg[i];
      end
    end
  end

  // first port direction byte, reset makes every line an input
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      first_dir_reg <= BIO_DIR_RESET;
    end else if (dir_wr[BIO_PORT_FIRST]) begin
      first_dir_reg <= BUS_WDATA;
    end
  end

  // second port direction byte
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      second_dir_reg <= BIO_DIR_RESET;
    end else if (dir_wr[BIO_PORT_SECOND]) begin
      second_dir_reg <= BUS_WDATA;
    end
  end

  // third port direction byte
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      third_dir_reg <= BIO_DIR_RESET;
    end else if (dir_wr[BIO_PORT_THIRD]) begin
      third_dir_reg <= BUS_WDATA;
    end
  end

  // fourth port direction byte
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      fourth_dir_reg <= BIO_DIR_RESET;
    end else if (dir_wr[BIO_PORT_FOURTH]) begin
      fourth_dir_reg <= BUS_WDATA;
    end
  end

  // first port latch: written whatever the direction, kept over reset
  always_ff @(posedge MCLK) begin
    if (data_wr[BIO_PORT_FIRST]) begin
      first_data_reg <= BUS_WDATA;
    end
  end

  // second port latch, no reset on purpose
  always_ff @(posedge MCLK) begin
    if (data_wr[BIO_PORT_SECOND]) begin
      second_data_reg <= BUS_WDATA;
    end
  end

  // third port latch, no reset on purpose
  always_ff @(posedge MCLK) begin
    if (data_wr[BIO_PORT_THIRD]) begin
      third_data_reg <= BUS_WDATA;
    end
  end

  // fourth port latch, no reset on purpose
  always_ff @(posedge MCLK) begin
    if (data_wr[BIO_PORT_FOURTH]) begin
      fourth_data_reg <= BUS_WDATA;
    end
  end

  // indexed views so the read mux can pick a port by address
  assign data_view[BIO_PORT_FIRST] = first_data_reg;
  assign data_view[BIO_PORT_SECOND] = second_data_reg;
  assign data_view[BIO_PORT_THIRD] = third_data_reg;
  assign data_view[BIO_PORT_FOURTH] = fourth_data_reg;
  assign dir_view[BIO_PORT_FIRST] = first_dir_reg;
  assign dir_view[BIO_PORT_SECOND] = second_dir_reg;
  assign dir_view[BIO_PORT_THIRD] = third_dir_reg;
  assign dir_view[BIO_PORT_FOURTH] = fourth_dir_reg;

  // read mux: direction byte as stored, data byte mixed per bit
  always_comb begin
    rdata_next = BIO_DATA_INIT;
    if (dir_sel) begin
      rdata_next = dir_view[port_idx];
    end else begin
      rdata_next = read_mix(dir_view[port_idx], data_view[port_idx],
                            pin_sync_reg[port_idx]);
    end
  end

  // registered read data, held until the next read
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA <= BIO_DATA_INIT;
    end else if (rd_en) begin
      BUS_RDATA <= rdata_next;
    end
  end

  // pin drive straight from latch flops, so a write shows next cycle
  assign FIRST_PORT_LINES_OUT = first_data_reg;
  assign SECOND_PORT_LINES_OUT = second_data_reg;
  assign THIRD_PORT_LINES_OUT = third_data_reg;
  assign FOURTH_PORT_LINES_OUT = fourth_data_reg;

  // output enables straight from the direction flops
  assign FIRST_PORT_LINES_OE = first_dir_reg;
  assign SECOND_PORT_LINES_OE = second_dir_reg;
  assign THIRD_PORT_LINES_OE = third_dir_reg;
  assign FOURTH_PORT_LINES_OE = fourth_dir_reg;

endmodule

// ---- test/bio_pins_model.sv ----
// Purpose: far side pins. Assumes: no pulls. Notes: released bits use ext
module bio_pins_model (
  input wire logic [31:0] oe, out, ext,
  output logic [31:0] pin);
  timeunit 1ns; timeprecision 1ps;
  // driven bits follow the port, released bits the far side
  assign pin = (oe & out) | (~oe & ext);
endmodule

// ---- test/bio_ports_props.sv ----
// Purpose: port checker. Assumes: one clock. Notes: bound to bio_ports
module bio_ports_props import bio_pkg::*; (
  input wire logic MCLK, RST_N, BUS_SEL, BUS_WR,
  input wire logic [2:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA, BUS_RDATA, FIRST_PORT_LINES_OE,
  input wire logic [7:0] FIRST_PORT_LINES_OUT, FOURTH_PORT_LINES_OUT);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // decode of accesses to the first port and its direction byte
  wire w = BUS_SEL && BUS_WR, r = BUS_SEL && !BUS_WR;
  wire wd = w && BUS_ADDR == 3'h4, wq = w && BUS_ADDR == 3'h0;
  wire [7:0] d = BUS_WDATA, oe = FIRST_PORT_LINES_OE, q = FIRST_PORT_LINES_OUT;
  chk_reset_in: assert property ($rose(RST_N) |-> oe == 8'h00)
    else $error("oe after reset");
  chk_dir_wr: assert property (wd |=> oe == $past(d))
    else $error("oe write");
  chk_data_wr: assert property (wq |=> q == $past(d))
    else $error("out write");
  chk_data_four: assert property (w && BUS_ADDR == 3'h3 |=>
    FOURTH_PORT_LINES_OUT == $past(d)) else $error("out four");
  chk_oe_hold: assert property (!wd |=> $stable(oe))
    else $error("oe moved");
  chk_out_hold: assert property (!wq |=> $stable(q))
    else $error("out moved");
  chk_read_dir: assert property (r && BUS_ADDR == 3'h4 |=>
    BUS_RDATA == $past(oe)) else $error("dir read");
  chk_read_latch: assert property (r && BUS_ADDR == 3'h0 && oe == 8'hFF
    |=> BUS_RDATA == $past(q)) else $error("latch read");
endmodule
bind bio_ports bio_ports_props u_chk (.MCLK(MCLK), .RST_N(RST_N),
  .BUS_SEL(BUS_SEL), .BUS_WR(BUS_WR), .BUS_ADDR(BUS_ADDR),
  .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
  .FIRST_PORT_LINES_OE(FIRST_PORT_LINES_OE),
  .FIRST_PORT_LINES_OUT(FIRST_PORT_LINES_OUT),
  .FOURTH_PORT_LINES_OUT(FOURTH_PORT_LINES_OUT));

// ---- test/tb_bidirectional_io_ports.sv ----
// Purpose: port bench. Assumes: far side model. Notes: 12 cycle reset
module tb_bidirectional_io_ports;
  import bio_pkg::*;
  timeunit 1ns; timeprecision 1ps;
  logic mclk = 0, rst_n = 0, sel = 0, wr = 0;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  wire [31:0] oe, out, pin;
  logic [31:0] ext = 32'h96C35A69;
  int miscompares = 0, comparisons = 0;
  always #4 mclk = ~mclk;
  bio_ports dut (.MCLK(mclk), .RST_N(rst_n), .BUS_SEL(sel), .BUS_WR(wr),
    .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_RDATA(rdata),
    .FIRST_PORT_LINES_IN(pin[7:0]), .FIRST_PORT_LINES_OUT(out[7:0]),
    .FIRST_PORT_LINES_OE(oe[7:0]), .SECOND_PORT_LINES_IN(pin[15:8]),
    .SECOND_PORT_LINES_OUT(out[15:8]), .SECOND_PORT_LINES_OE(oe[15:8]),
    .THIRD_PORT_LINES_IN(pin[23:16]), .THIRD_PORT_LINES_OUT(out[23:16]),
    .THIRD_PORT_LINES_OE(oe[23:16]), .FOURTH_PORT_LINES_IN(pin[31:24]),
    .FOURTH_PORT_LINES_OUT(out[31:24]), .FOURTH_PORT_LINES_OE(oe[31:24]));
  bio_pins_model far (.oe(oe), .out(out), .ext(ext), .pin(pin));
  // compare and count
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (e !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one bus access, settled at the following falling edge
  task automatic acc(logic w, logic [2:0] a, logic [7:0] d);
    @(posedge mclk);
    sel <= 1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    sel <= 0;
    @(negedge mclk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // latch written while pins are inputs, reads follow the far side
  task automatic t_input;
    for (int p = 0; p < 4; p++) begin
      acc(1, 3'(p), 8'h3C);
      chk("oe", 8'h00, oe[8*p+:8]);
      chk("out", 8'h3C, out[8*p+:8]);
      acc(0, 3'(p), 8'h00);
      chk("rd", ext[8*p+:8], rdata);
    end
  endtask
  // upper nibble driven, reads mix latch and pins
  task automatic t_output;
    for (int p = 0; p < 4; p++) begin
      acc(1, 3'(p + 4), 8'hF0);
      chk("oe", 8'hF0, oe[8*p+:8]);
      acc(1, 3'(p), 8'h5A);
      chk("pin", {4'h5, ext[8*p+:4]}, pin[8*p+:8]);
      acc(0, 3'(p), 8'h00);
      chk("rd", {4'h5, ext[8*p+:4]}, rdata);
      acc(0, 3'(p + 4), 8'h00);
      chk("dir", 8'hF0, rdata);
    end
  endtask
  // reset clears direction but keeps the latch
  task automatic t_reset;
    acc(1, 3'h4, 8'hFF);
    acc(0, 3'h0, 8'h00);
    chk("rd", 8'h5A, rdata);
    @(posedge mclk) rst_n <= 0;
    @(posedge mclk) rst_n <= 1;
    @(negedge mclk);
    for (int p = 0; p < 4; p++) chk("oe", 8'h00, oe[8*p+:8]);
    chk("out", 8'h5A, out[7:0]);
  endtask
  // main sequence after a 12 cycle reset
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    t_input();
    t_output();
    t_reset();
    end_of_test();
  end
  // watchdog well beyond the under 70 cycles of the run
  initial begin
    #20us;
    miscompares++;
    end_of_test();
  end
endmodule
